// file: shared/ccfg_params.svh
// Constants for the calibration config and interface decode block
`ifndef CCFG_PARAMS_SVH
`define CCFG_PARAMS_SVH
// Interface select codes
`define CCFG_SEL_HOLD0    4'h0
`define CCFG_SEL_ADDR_LO  4'h6
`define CCFG_SEL_ADDR_MID 4'h7
`define CCFG_SEL_PTR      4'h8
`define CCFG_SEL_CMD      4'h9
`define CCFG_SEL_DUR      4'hA
`define CCFG_SEL_ASEL     4'hB
`define CCFG_SEL_RELEARN  4'hF
`define CCFG_RELEARN_DATA 4'hF
// Command and calibration register codes
`define CCFG_CMD_LOAD_CAL  4'h0
`define CCFG_CAL_CONFIG    4'h0
`define CCFG_CAL_OFFSET    4'h1
`define CCFG_CAL_OFFSET_TC 4'h2
`define CCFG_CAL_SPAN      4'h3
`define CCFG_CAL_SPAN_TC   4'h4
// Lock word
`define CCFG_LOCK_KEY      8'hFF
`define CCFG_LOCK_LSB      0
`define CCFG_LOCK_MSB      7
// Reset values
`define CCFG_CONFIG_RST    16'h0000
`define CCFG_WORD_RST      16'h0000
`define CCFG_NIB_RST       4'h0
// Temperature index lookup map
`define CCFG_LUT_SPLIT     8'h80
`define CCFG_LUT_LAST      8'hAF
`define CCFG_LUT_OFF_LO    10'h000
`define CCFG_LUT_SPAN_LO   10'h200
`define CCFG_LUT_OFF_HI    10'h100
`define CCFG_LUT_SPAN_HI   10'h1A0
// Read-back pointer decode
`define CCFG_RB_HOLD_LO    4'h0
`define CCFG_RB_HOLD_HI    4'h1
`define CCFG_RB_ADDR_A     4'h2
`define CCFG_RB_CMD_PTR    4'h3
`define CCFG_RB_ANALOG     4'h4
`define CCFG_RB_EE_ADDR    4'h5
`define CCFG_RB_TEMP       4'h7
`define CCFG_RB_PATTERN    8'hCA
`endif

// file: shared/ccfg_pkg.sv
// Types shared by the calibration config block
`default_nettype none
package ccfg_pkg;
  // Calibration configuration word, bit 15 first
  typedef struct packed {
    logic [2:0] osc_trim;
    logic       ext_resistor_sel;
    logic       clock_out_enable;
    logic       input_invert;
    logic       coarse_offset_polarity;
    logic [2:0] coarse_input_offset;
    logic [3:0] gain_code;
    logic       offset_dac_polarity;
    logic       offset_tc_polarity;
  } ccfg_cfg_t;
  // One nibble write from the serial framer
  typedef struct packed {
    logic       valid;
    logic [3:0] sel;
    logic [3:0] data;
  } ccfg_wr_t;
  // Write enables from the select decode
  typedef struct packed {
    logic addr_lo;
    logic addr_mid;
    logic ptr;
    logic cmd;
    logic dur;
    logic asel;
    logic relearn;
  } ccfg_we_t;
endpackage
`default_nettype wire

// file: rtl/ccfg_nibble_decode.sv
// Select nibble decode into interface register write enables
`include "ccfg_params.svh"
`default_nettype none
module ccfg_nibble_decode
  import ccfg_pkg::*;
#(
  parameter int HOLD_NIBBLES = 4
)(
  // Nibble write
  input  wire ccfg_wr_t               wr,
  input  wire logic                   enable,
  // Write enables
  output wire logic [HOLD_NIBBLES-1:0] hold_we,
  output var  ccfg_we_t               we
);
  ////////////////////////////////////////////////////////////////
  // Parameter check
  if (HOLD_NIBBLES < 1 || HOLD_NIBBLES > 4)
  begin : g_bad
    $error("HOLD_NIBBLES must be 1 to 4");
  end

  wire logic go;
  assign go = wr.valid & enable;

  // One enable per data-hold nibble
  for (genvar i = 0; i < HOLD_NIBBLES; i++)
  begin : g_hold
    assign hold_we[i] = go && (wr.sel == (`CCFG_SEL_HOLD0 + 4'(i)));
  end

  ////////////////////////////////////////////////////////////////
  // Remaining select codes; reserved codes enable nothing
  always_comb
  begin
    we          = '0;
    we.addr_lo  = go && wr.sel == `CCFG_SEL_ADDR_LO;
    we.addr_mid = go && wr.sel == `CCFG_SEL_ADDR_MID;
    we.ptr      = go && wr.sel == `CCFG_SEL_PTR;
    we.cmd      = go && wr.sel == `CCFG_SEL_CMD;
    we.dur      = go && wr.sel == `CCFG_SEL_DUR;
    we.asel     = go && wr.sel == `CCFG_SEL_ASEL;
    we.relearn  = go && wr.sel == `CCFG_SEL_RELEARN
                  && wr.data == `CCFG_RELEARN_DATA;
  end
endmodule
`default_nettype wire

// file: rtl/ccfg_lut_map.sv
// Temperature index to lookup table byte addresses
`include "ccfg_params.svh"
`default_nettype none
module ccfg_lut_map
(
  // Index in
  input  wire logic [7:0] temp_index,
  // Low byte addresses out
  output var  logic [9:0] offset_addr,
  output var  logic [9:0] span_addr,
  output var  logic       in_range
);
  ////////////////////////////////////////////////////////////////
  // Two index bands, two bytes per entry
  always_comb
  begin
    logic [9:0] step;
    step        = {1'b0, temp_index[6:0], 1'b0};
    offset_addr = `CCFG_LUT_OFF_LO + step;
    span_addr   = `CCFG_LUT_SPAN_LO + step;
    in_range    = 1'b1;
    if (temp_index >= `CCFG_LUT_SPLIT)
    begin
      offset_addr = `CCFG_LUT_OFF_HI + step;
      span_addr   = `CCFG_LUT_SPAN_HI + step;
      in_range    = temp_index <= `CCFG_LUT_LAST;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ccfg_top.sv
// Calibration configuration and interface register bank
`include "ccfg_params.svh"
`default_nettype none
module ccfg_top
  import ccfg_pkg::*;
#(
  parameter int HOLD_NIBBLES = 4
)(
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Nibble writes from the serial framer
  input  wire ccfg_wr_t   wr_req,
  // Lock word load from memory
  input  wire logic       lock_load,
  input  wire logic [15:0] lock_data,
  // Temperature index
  input  wire logic [7:0] temp_index,
  // Interface register set
  output wire logic [15:0] data_hold,
  output wire logic [3:0] cal_reg_addr,
  output wire logic [9:0] eeprom_addr,
  output wire logic [3:0] readback_pointer,
  output wire logic [3:0] command_code,
  output wire logic       command_go,
  output wire logic [3:0] analog_duration,
  output wire logic [3:0] analog_select,
  output wire logic       baud_relearn,
  output wire logic [7:0] readback_byte,
  // Calibration registers
  output wire ccfg_cfg_t  config_word,
  output wire logic [15:0] offset_trim_dac,
  output wire logic [15:0] offset_tc_dac,
  output wire logic [15:0] span_trim_dac,
  output wire logic [15:0] span_tc_dac,
  output wire logic signed [3:0] coarse_offset_steps,
  // Lock
  output wire logic [15:0] lock_word,
  output wire logic       serial_disable,
  output wire logic       out_route_amp,
  // Lookup addresses
  output wire logic [9:0] lut_offset_addr,
  output wire logic [9:0] lut_span_addr,
  output wire logic       lut_in_range
);
  ////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end
    else if (ce)
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State
  logic [15:0] hold_reg, hold_next;
  logic [3:0]  addr_lo_reg, addr_lo_next;
  logic [3:0]  addr_mid_reg, addr_mid_next;
  logic [3:0]  ptr_reg, ptr_next;
  logic [3:0]  cmd_reg, cmd_next;
  logic        go_reg, go_next;
  logic [3:0]  dur_reg, dur_next;
  logic [3:0]  asel_reg, asel_next;
  logic        relearn_reg, relearn_next;
  logic [7:0]  rb_reg, rb_next;
  ccfg_cfg_t   cfg_reg, cfg_next;
  logic [15:0] offset_trim_dac_reg, offset_trim_dac_next;
  logic [15:0] otc_reg, otc_next;
  logic [15:0] span_reg, span_next;
  logic [15:0] stc_reg, stc_next;
  logic signed [3:0] steps_reg, steps_next;
  logic [15:0] lock_reg, lock_next;
  logic        sdis_reg, sdis_next;
  logic [9:0]  lut_off_reg, lut_span_reg;
  logic        lut_ok_reg;

  ////////////////////////////////////////////////////////////////
  // Decode and lookup
  logic                    locked;
  logic [HOLD_NIBBLES-1:0] hold_we;
  ccfg_we_t                we;
  logic [9:0]              map_off, map_span;
  logic                    map_ok;

  // Serial writes ignored while locked
  assign locked = lock_reg[`CCFG_LOCK_MSB:`CCFG_LOCK_LSB] == `CCFG_LOCK_KEY;

  ccfg_nibble_decode #(
    .HOLD_NIBBLES (HOLD_NIBBLES)
  ) u_decode (
    .wr      (wr_req),
    .enable  (!locked),
    .hold_we (hold_we),
    .we      (we)
  );

  ccfg_lut_map u_lut (
    .temp_index  (temp_index),
    .offset_addr (map_off),
    .span_addr   (map_span),
    .in_range    (map_ok)
  );

  ////////////////////////////////////////////////////////////////
  // Interface register next values
  always_comb
  begin
    hold_next     = hold_reg;
    addr_lo_next  = we.addr_lo ? wr_req.data : addr_lo_reg;
    addr_mid_next = we.addr_mid ? wr_req.data : addr_mid_reg;
    ptr_next      = we.ptr ? wr_req.data : ptr_reg;
    cmd_next      = we.cmd ? wr_req.data : cmd_reg;
    go_next       = we.cmd;
    dur_next      = we.dur ? wr_req.data : dur_reg;
    asel_next     = we.asel ? wr_req.data : asel_reg;
    relearn_next  = we.relearn;
    for (int i = 0; i < HOLD_NIBBLES; i++)
    begin
      if (hold_we[i])
      begin
        hold_next[i*4 +: 4] = wr_req.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read-back byte chosen by the pointer
  always_comb
  begin
    case (ptr_reg)
      `CCFG_RB_HOLD_LO: rb_next = hold_reg[7:0];
      `CCFG_RB_HOLD_HI: rb_next = hold_reg[15:8];
      `CCFG_RB_ADDR_A:  rb_next = {addr_mid_reg, addr_lo_reg};
      `CCFG_RB_CMD_PTR: rb_next = {cmd_reg, ptr_reg};
      `CCFG_RB_ANALOG:  rb_next = {asel_reg, dur_reg};
      `CCFG_RB_EE_ADDR: rb_next = {addr_mid_reg, addr_lo_reg};
      `CCFG_RB_TEMP:    rb_next = temp_index;
      default:          rb_next = `CCFG_RB_PATTERN;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Calibration registers, loaded by the load command
  always_comb
  begin
    logic ld;
    ld        = we.cmd && wr_req.data == `CCFG_CMD_LOAD_CAL;
    cfg_next  = cfg_reg;
    offset_trim_dac_next = offset_trim_dac_reg;
    otc_next  = otc_reg;
    span_next = span_reg;
    stc_next  = stc_reg;
    if (ld)
    begin
      case (addr_lo_reg)
        `CCFG_CAL_CONFIG:    cfg_next  = ccfg_cfg_t'(hold_reg);
        `CCFG_CAL_OFFSET:    offset_trim_dac_next = hold_reg;
        `CCFG_CAL_OFFSET_TC: otc_next  = hold_reg;
        `CCFG_CAL_SPAN:      span_next = hold_reg;
        `CCFG_CAL_SPAN_TC:   stc_next  = hold_reg;
        default:             cfg_next  = cfg_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Signed coarse offset step count, lock state
  always_comb
  begin
    logic signed [3:0] mag;
    mag        = signed'({1'b0, cfg_reg.coarse_input_offset});
    steps_next = cfg_reg.coarse_offset_polarity ? mag : -mag;
    lock_next  = lock_load ? lock_data : lock_reg;
    sdis_next  = locked;
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hold_reg     <= `CCFG_WORD_RST;
      addr_lo_reg  <= `CCFG_NIB_RST;
      addr_mid_reg <= `CCFG_NIB_RST;
      ptr_reg      <= `CCFG_NIB_RST;
      cmd_reg      <= `CCFG_NIB_RST;
      go_reg       <= 1'b0;
      dur_reg      <= `CCFG_NIB_RST;
      asel_reg     <= `CCFG_NIB_RST;
      relearn_reg  <= 1'b0;
      rb_reg       <= 8'h00;
      cfg_reg      <= ccfg_cfg_t'(`CCFG_CONFIG_RST);
      offset_trim_dac_reg     <= `CCFG_WORD_RST;
      otc_reg      <= `CCFG_WORD_RST;
      span_reg     <= `CCFG_WORD_RST;
      stc_reg      <= `CCFG_WORD_RST;
      steps_reg    <= 4'sh0;
      lock_reg     <= `CCFG_WORD_RST;
      sdis_reg     <= 1'b0;
      lut_off_reg  <= 10'h000;
      lut_span_reg <= 10'h000;
      lut_ok_reg   <= 1'b0;
    end
    else if (ce)
    begin
      hold_reg     <= hold_next;
      addr_lo_reg  <= addr_lo_next;
      addr_mid_reg <= addr_mid_next;
      ptr_reg      <= ptr_next;
      cmd_reg      <= cmd_next;
      go_reg       <= go_next;
      dur_reg      <= dur_next;
      asel_reg     <= asel_next;
      relearn_reg  <= relearn_next;
      rb_reg       <= rb_next;
      cfg_reg      <= cfg_next;
      offset_trim_dac_reg     <= offset_trim_dac_next;
      otc_reg      <= otc_next;
      span_reg     <= span_next;
      stc_reg      <= stc_next;
      steps_reg    <= steps_next;
      lock_reg     <= lock_next;
      sdis_reg     <= sdis_next;
      lut_off_reg  <= map_off;
      lut_span_reg <= map_span;
      lut_ok_reg   <= map_ok;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs straight from registers
  assign data_hold        = hold_reg;
  assign cal_reg_addr     = addr_lo_reg;
  assign eeprom_addr      = {ptr_reg[1:0], addr_mid_reg, addr_lo_reg};
  assign readback_pointer = ptr_reg;
  assign command_code     = cmd_reg;
  assign command_go       = go_reg;
  assign analog_duration  = dur_reg;
  assign analog_select    = asel_reg;
  assign baud_relearn     = relearn_reg;
  assign readback_byte    = rb_reg;
  // Config fields drive resistor, clock, input and sign controls
  assign config_word      = cfg_reg;
  assign offset_trim_dac  = offset_trim_dac_reg;
  assign offset_tc_dac    = otc_reg;
  assign span_trim_dac    = span_reg;
  assign span_tc_dac      = stc_reg;
  assign coarse_offset_steps = steps_reg;
  assign lock_word        = lock_reg;
  assign serial_disable   = sdis_reg;
  assign out_route_amp    = sdis_reg;
  assign lut_offset_addr  = lut_off_reg;
  assign lut_span_addr    = lut_span_reg;
  assign lut_in_range     = lut_ok_reg;

  ////////////////////////////////////////////////////////////////
  // Checks
  a_hold_nibble_store: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && !locked && wr_req.sel == 4'h2
    |=> hold_reg[11:8] == $past(wr_req.data) && hold_reg[7:0] == $past(hold_reg[7:0]))
    else $error("data hold nibble not stored");
  a_addr_low_store: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && !locked && wr_req.sel == 4'h6
    |=> cal_reg_addr == $past(wr_req.data) && eeprom_addr[3:0] == $past(wr_req.data))
    else $error("shared low address not stored");
  a_addr_mid_store: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && !locked && wr_req.sel == 4'h7
    |=> eeprom_addr[7:4] == $past(wr_req.data))
    else $error("address bits 7:4 not stored");
  a_ptr_addr_bits: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && !locked && wr_req.sel == 4'h8
    |=> readback_pointer == $past(wr_req.data) && eeprom_addr[9:8] == $past(wr_req.data[1:0]))
    else $error("pointer or address bits 9:8 wrong");
  a_cmd_pulse_once: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && !locked && wr_req.sel == 4'h9
    |=> command_go && command_code == $past(wr_req.data) ##1 (!command_go || $past(we.cmd) || !$past(ce)))
    else $error("command not taken as one pulse");
  a_dur_sel_store: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && !locked && wr_req.sel == 4'hA
    |=> analog_duration == $past(wr_req.data) && $stable(analog_select))
    else $error("duration not stored");
  a_asel_store: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && !locked && wr_req.sel == 4'hB
    |=> analog_select == $past(wr_req.data))
    else $error("analog select not stored");
  a_relearn_only_ff: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce |=> baud_relearn == ($past(wr_req.valid) && !$past(locked)
                            && $past(wr_req.sel) == 4'hF && $past(wr_req.data) == 4'hF))
    else $error("relearn pulse wrong");
  a_reserved_keep: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && wr_req.valid && (wr_req.sel inside {4'h4, 4'h5, 4'hC, 4'hD, 4'hE})
    |=> $stable(hold_reg) && $stable(eeprom_addr) && $stable(command_code)
        && $stable(analog_duration) && $stable(analog_select))
    else $error("reserved select changed a register");
  a_lock_blocks_wr: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && locked |=> serial_disable && out_route_amp && $stable(hold_reg) && !command_go)
    else $error("locked device took a write");
  a_cal_load_word: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && we.cmd && wr_req.data == 4'h0 && addr_lo_reg == 4'h3
    |=> span_trim_dac == $past(hold_reg) && $stable(offset_trim_dac))
    else $error("calibration load wrong");
  a_lut_high_band: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && temp_index == 8'h80 ##1 ce
    |-> lut_offset_addr == 10'h100 && lut_span_addr == 10'h1A0 && lut_in_range)
    else $error("lookup map wrong at band start");
  a_coarse_negative: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ce && !cfg_reg.coarse_offset_polarity && cfg_reg.coarse_input_offset == 3'h7
    |=> coarse_offset_steps == -4'sd7)
    else $error("coarse offset sign wrong");
endmodule
`default_nettype wire

// file: test/ccfg_tester.sv
// Calibration tester model that drives nibble writes into the block
`default_nettype none
module ccfg_tester
  import ccfg_pkg::*;
#(
  parameter logic [2:0] OSC_KEEP = 3'h0
)(
  // Clock
  input  wire logic     sys_clk,
  // Nibble writes
  output var  ccfg_wr_t wr_req
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // Idle until the first request
  initial wr_req = '0;
  // One nibble, held up so back-to-back sends run every cycle
  task automatic send(input logic [3:0] sel, input logic [3:0] data);
    @(negedge sys_clk);
    wr_req <= '{valid: 1'b1, sel: sel, data: data};
    @(posedge sys_clk);
  endtask
  // Drop the request line
  task automatic idle();
    @(negedge sys_clk);
    wr_req <= '0;
  endtask
  // Baud relearn code: select and data all ones
  task automatic relearn();
    send(4'hF, 4'hF);
    idle();
  endtask
  // Hold word, target address, then load command
  task automatic write_cal(input logic [3:0] addr, input logic [15:0] value);
    logic [15:0] v;
    v = value;
    if (addr == 4'h0)
    begin
      v[15:13] = OSC_KEEP;
    end
    for (int i = 0; i < 4; i++)
    begin
      send(i[3:0], v[4*i +: 4]);
    end
    send(4'h6, addr);
    send(4'h9, 4'h0);
    idle();
  endtask
endmodule
`default_nettype wire

// file: test/ccfg_top_tb.sv
// Self-checking bench for the calibration config and decode block
`default_nettype none
module ccfg_top_tb
  import ccfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, ce, lock_load, command_go, baud_relearn, serial_disable, out_route_amp, lut_in_range;
  logic [15:0] lock_data, data_hold, offset_trim_dac, offset_tc_dac, span_trim_dac, span_tc_dac, lock_word;
  logic [7:0] temp_index, readback_byte;
  logic [3:0] cal_reg_addr, readback_pointer, command_code, analog_duration, analog_select;
  logic [9:0] eeprom_addr, lut_offset_addr, lut_span_addr, d;
  logic signed [3:0] coarse_offset_steps;
  ccfg_cfg_t config_word;
  ccfg_wr_t wr_req;
  logic [45:0] snap;
  logic [7:0] tix [5] = '{8'h00, 8'h7F, 8'h80, 8'hAF, 8'hB0};
  logic [3:0] rsv [6] = '{4'h4, 4'h5, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [3:0] rbp [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hA};
  logic [7:0] rbx [5] = '{8'hBC, 8'h9A, 8'h53, 8'h27, 8'hCA};
  int err_total = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////
  // Design and tester
  ccfg_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .wr_req(wr_req), .lock_load(lock_load),
    .lock_data(lock_data), .temp_index(temp_index), .data_hold(data_hold), .cal_reg_addr(cal_reg_addr),
    .eeprom_addr(eeprom_addr), .readback_pointer(readback_pointer), .command_code(command_code),
    .command_go(command_go), .analog_duration(analog_duration), .analog_select(analog_select),
    .baud_relearn(baud_relearn), .readback_byte(readback_byte), .config_word(config_word),
    .offset_trim_dac(offset_trim_dac), .offset_tc_dac(offset_tc_dac), .span_trim_dac(span_trim_dac),
    .span_tc_dac(span_tc_dac), .coarse_offset_steps(coarse_offset_steps), .lock_word(lock_word),
    .serial_disable(serial_disable), .out_route_amp(out_route_amp), .lut_offset_addr(lut_offset_addr),
    .lut_span_addr(lut_span_addr), .lut_in_range(lut_in_range));
  ccfg_tester tester (.sys_clk(sys_clk), .wr_req(wr_req));
  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (err_total == 0 && num_checks > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Lock word load, waits out the two-cycle lag
  task automatic lock(input logic [15:0] v);
    @(negedge sys_clk);
    lock_load <= 1'b1;
    lock_data <= v;
    @(negedge sys_clk);
    lock_load <= 1'b0;
    @(negedge sys_clk);
  endtask
  // Calibration register picked by address
  function automatic logic [15:0] cal_out(input int a);
    case (a)
      1: return offset_trim_dac;
      2: return offset_tc_dac;
      3: return span_trim_dac;
      default: return span_tc_dac;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard, far beyond the hundred or so cycles of the tests
  initial
  begin
    #(5000 * 10);
    err_total++;
    results();
  end
  // Test sequence
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    lock_load = 1'b0;
    lock_data = 16'h0000;
    temp_index = 8'h00;
    repeat (2) @(negedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
    // Interface register writes, back to back
    for (int i = 0; i < 4; i++)
    begin
      tester.send(i[3:0], 4'hC - i[3:0]);
    end
    tester.send(4'h6, 4'h3);
    tester.send(4'h7, 4'h5);
    tester.send(4'h8, 4'hE);
    tester.send(4'hA, 4'h7);
    tester.send(4'hB, 4'h2);
    tester.idle();
    chk(data_hold, 16'h9ABC, "hold");
    chk(cal_reg_addr, 4'h3, "cal addr");
    chk(eeprom_addr, 10'h253, "ee addr");
    chk(readback_pointer, 4'hE, "pointer");
    chk(analog_duration, 4'h7, "duration");
    chk(analog_select, 4'h2, "select");
    tester.send(4'h9, 4'h5);
    tester.idle();
    chk(command_code, 4'h5, "command");
    chk(command_go, 1'b1, "go pulse");
    // Read-back byte follows the pointer one cycle later
    foreach (rbp[k])
    begin
      tester.send(4'h8, rbp[k]);
      tester.idle();
      @(negedge sys_clk);
      chk(readback_byte, rbx[k], "readback");
    end
    // Reserved selects and a wrong relearn data nibble
    snap = {data_hold, cal_reg_addr, eeprom_addr, readback_pointer, command_code, analog_duration, analog_select};
    foreach (rsv[k])
    begin
      tester.send(rsv[k], 4'h1);
    end
    tester.idle();
    chk({data_hold, cal_reg_addr, eeprom_addr, readback_pointer, command_code, analog_duration, analog_select},
      snap, "reserved");
    chk(baud_relearn, 1'b0, "no relearn");
    tester.relearn();
    chk(baud_relearn, 1'b1, "relearn");
    @(negedge sys_clk);
    chk(baud_relearn, 1'b0, "relearn end");
    // Frozen clock enable drops a write
    ce <= 1'b0;
    tester.send(4'hA, 4'h9);
    tester.idle();
    ce <= 1'b1;
    chk(analog_duration, 4'h7, "ce freeze");
    // Configuration word and its fields
    tester.write_cal(4'h0, 16'h1FC3);
    @(negedge sys_clk);
    chk(config_word, 16'h1FC3, "config");
    chk({config_word.ext_resistor_sel, config_word.clock_out_enable, config_word.input_invert,
      config_word.offset_dac_polarity, config_word.offset_tc_polarity}, 5'b11111, "fields set");
    chk($unsigned(coarse_offset_steps), 4'h7, "coarse plus");
    tester.write_cal(4'h0, 16'hE1C0);
    @(negedge sys_clk);
    chk(config_word, 16'h01C0, "config two");
    chk({config_word.ext_resistor_sel, config_word.clock_out_enable, config_word.input_invert,
      config_word.offset_dac_polarity, config_word.offset_tc_polarity}, 5'b00000, "fields clear");
    chk($unsigned(coarse_offset_steps), 4'h9, "coarse minus");
    // DAC registers through the load command
    for (int a = 1; a < 5; a++)
    begin
      tester.write_cal(a[3:0], 16'(a * 32'h2345));
      chk(cal_out(a), 16'(a * 32'h2345), "cal load");
    end
    chk(config_word, 16'h01C0, "config kept");
    // Temperature index map, both ranges and beyond
    foreach (tix[k])
    begin
      temp_index <= tix[k];
      @(negedge sys_clk);
      d = {2'b00, tix[k][6:0], 1'b0};
      chk(lut_in_range, tix[k] <= 8'hAF, "in range");
      if (tix[k] <= 8'hAF)
      begin
        chk(lut_offset_addr, (tix[k][7] ? 10'h100 : 10'h000) + d, "lut offset");
        chk(lut_span_addr, (tix[k][7] ? 10'h1A0 : 10'h200) + d, "lut span");
      end
    end
    // Lock only on a full low byte
    lock(16'hFFFE);
    chk(serial_disable, 1'b0, "not locked");
    tester.send(4'hB, 4'h6);
    tester.idle();
    chk(analog_select, 4'h6, "open write");
    lock(16'hA5FF);
    chk({lock_word, serial_disable, out_route_amp}, {16'hA5FF, 2'b11}, "locked");
    tester.send(4'hB, 4'h9);
    tester.idle();
    chk(analog_select, 4'h6, "locked write");
    tester.relearn();
    chk(baud_relearn, 1'b0, "locked relearn");
    results();
  end
endmodule
`default_nettype wire
